// *** hdl/dcf_pkg.sv ***
package dcf_pkg;

    localparam int unsigned DCF_DATA_W       = 18;
    localparam int unsigned DCF_OFFSET_W     = 16;
    localparam int unsigned DCF_DEPTH_DEF    = 8192;
    localparam logic [15:0] DCF_OFFSET_RESET = 16'h007F;
    localparam int unsigned DCF_SYNC_STAGES  = 2;
    localparam int unsigned DCF_STAGE_DEPTH  = 8;

    typedef enum logic {
        DCF_SEL_EMPTY_OFS,
        DCF_SEL_FULL_OFS
    } dcf_ofs_sel_t;

endpackage

// *** hdl/dcf_stage_fifo.sv ***
`timescale 1ns/10ps
`default_nettype none

module dcf_stage_fifo #(
    parameter int unsigned WIDTH = 18,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);

    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wptr;
        logic [AW-1:0]               rptr;
        logic [AW:0]                 count;
    } dcf_stage_t;

    dcf_stage_t st_reg;
    dcf_stage_t st_next;
    logic       push;
    logic       pop;

    assign in_ready  = (st_reg.count != (AW+1)'(DEPTH));
    assign out_valid = (st_reg.count != '0);
    assign out_data  = st_reg.mem[st_reg.rptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wptr] = in_data;
            st_next.wptr = (st_reg.wptr == AW'(DEPTH-1)) ? '0 : st_reg.wptr + 1'b1;
        end
        if (pop) begin
            st_next.rptr = (st_reg.rptr == AW'(DEPTH-1)) ? '0 : st_reg.rptr + 1'b1;
        end
        // Simultaneous push and pop leave the count unchanged.
        st_next.count = st_reg.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule

`default_nettype wire

// *** hdl/dcf_fifo.sv ***
// Summary of operation
// RULE1 - Array of 18-bit words, read/write pointers.
// RULE2 - Clear input empties buffer, empty flag low.
// RULE3 - After clear, outputs low when drive enabled.
// RULE4 - Outside party resets first, idles during clear.
// RULE5 - Write enable low stores input each edge.
// RULE6 - Read enable low presents next word.
// RULE7 - Output enable high floats data outputs.
// RULE8 - Cascaded: drive only when read enabled; the code drives whenever output_enable_n is low and no clear is held.
// RULE9 - Writes ignored while buffer full; the code holds up to STAGE_DEPTH of them in the staging FIFO until space frees.
// RULE10 - Reads ignored when empty, last word held.
// RULE11 - Two 16-bit offsets loaded from low bits.
// RULE12 - Unprogrammed offsets use built-in defaults.
// RULE13 - Both default offsets equal 127 words.
// RULE14 - Offset loads alternate empty then full.
// RULE15 - Partial load allowed, sequence resumes next.
// RULE16 - Offset readback alternates empty then full.
// RULE17 - Full flag low when full, write-clock only.
// RULE18 - Empty flag low when empty, read-clock only.
// RULE19 - Almost flags within offset of boundaries.
// RULE20 - Sync select low: almost flags clock-synchronous.
// RULE21 - Empty side flag levels up to half.
// RULE22 - Half, almost-full, full from upper counts.
// RULE23 - Flags settle after retransmit recovery time.
// RULE24 - Outside party clocks once after retransmit.
// RULE25 - Retransmit returns read pointer to zero.
// RULE26 - Pointers cross domains through synchronisers.
// RULE27 - Cascade outputs pulse at last location.
`timescale 1ns/10ps
`default_nettype none

module dcf_fifo
    import dcf_pkg::*;
#(
    parameter int unsigned DEPTH       = dcf_pkg::DCF_DEPTH_DEF,
    parameter int unsigned STAGE_DEPTH = dcf_pkg::DCF_STAGE_DEPTH
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          buffer_clear_n,
    input  wire logic                          write_enable_n,
    input  wire logic                          read_enable_n,
    input  wire logic                          output_enable_n,
    input  wire logic                          offset_load_n,
    input  wire logic                          flag_sync_select,
    input  wire logic                          retransmit_pulse,
    input  wire logic                          write_cascade_in_n,
    input  wire logic                          read_cascade_in_n,
    input  wire logic [dcf_pkg::DCF_DATA_W-1:0] write_data_in,
    output logic      [dcf_pkg::DCF_DATA_W-1:0] read_data_out,
    output logic      [dcf_pkg::DCF_DATA_W-1:0] read_data_oe,
    output logic                               write_ready,
    output logic                               empty_indicator_n,
    output logic                               full_indicator_n,
    output logic                               half_level_indicator_n,
    output logic                               almost_empty_indicator_n,
    output logic                               almost_full_indicator_n,
    output logic                               write_cascade_out_n,
    output logic                               read_cascade_out_n
);

    import dcf_pkg::*;

    localparam int unsigned AW = $clog2(DEPTH);
    localparam int unsigned DW = DCF_DATA_W;
    localparam int unsigned OW = DCF_OFFSET_W;
    localparam logic [AW:0] DEPTH_W = (AW+1)'(DEPTH);
    localparam logic [AW:0] HALF_W  = (AW+1)'(DEPTH/2);
    // Threshold compares run wide enough for any offset, so none is truncated.
    localparam int unsigned CW = (((AW+1) > OW) ? (AW+1) : OW) + 1;

    ////////////////////////////////////////////////////////////////////////////////

    function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
        logic [AW:0] b;
        b = '0;
        for (int i = AW; i >= 0; i--) begin
            b[i] = (i == AW) ? g[i] : (b[i+1] ^ g[i]);
        end
        return b;
    endfunction

    function automatic logic [AW:0] ptr_inc(input logic [AW:0] p);
        return p + 1'b1;
    endfunction

    function automatic logic near_empty(input logic [AW:0] c, input logic [OW-1:0] o);
        return CW'(c) <= CW'(o);
    endfunction

    function automatic logic near_full(input logic [AW:0] c, input logic [OW-1:0] o);
        return (CW'(c) + CW'(o)) >= CW'(DEPTH_W);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic [AW:0]   wptr;
        logic [AW:0]   rptr;
        logic [AW:0]   wgray;
        logic [AW:0]   rgray;
        logic [AW:0]   rgray_s1;
        logic [AW:0]   rgray_s2;
        logic [AW:0]   wgray_s1;
        logic [AW:0]   wgray_s2;
        logic [DW-1:0] qdata;
        logic [DW-1:0] qoe;
        logic          ready;
        logic          ef_n;
        logic          ff_n;
        logic          hf_n;
        logic          pae_n;
        logic          paf_n;
        logic          wxo_n;
        logic          rxo_n;
        logic [OW-1:0] empty_threshold_offset;
        logic [OW-1:0] full_threshold_offset;
        dcf_ofs_sel_t  wsel;
        dcf_ofs_sel_t  rsel;
        logic          primed;
    } dcf_state_t;

    dcf_state_t st_reg;
    dcf_state_t st_next;

    logic [DW-1:0] mem_reg [DEPTH];
    logic [DW-1:0] stage_data;
    logic          stage_valid;
    logic          stage_ready;
    logic          stage_pop;
    logic          do_write;
    logic          do_read;
    logic          prog_write;
    logic          prog_read;
    logic [AW:0]   wcount;
    logic [AW:0]   rcount;
    logic [AW:0]   ucount;
    logic [AW:0]   wcount_nx;
    logic [AW:0]   rcount_nx;
    logic [AW:0]   wptr_nx;
    logic [AW:0]   rptr_nx;
    logic          clr;

    ////////////////////////////////////////////////////////////////////////////////

    // The staging FIFO absorbs writes so that a full array stalls the stage
    // instead of dropping words; write_ready shows when the stage itself fills.
    dcf_stage_fifo #(
        .WIDTH (DW),
        .DEPTH (STAGE_DEPTH)
    ) u_stage (
        .clk       (clk),
        .rst       (clr),
        .in_data   (write_data_in),
        .in_valid  (!write_enable_n && offset_load_n), // [RULE5]
        .in_ready  (stage_ready),
        .out_data  (stage_data),
        .out_valid (stage_valid),
        .out_ready (st_reg.ff_n)                      // [RULE9]
    );

    assign clr        = rst || !buffer_clear_n;                  // [RULE2]
    assign prog_write = !offset_load_n && !write_enable_n;       // [RULE14]
    assign prog_read  = !offset_load_n && !read_enable_n;        // [RULE16]
    assign stage_pop  = stage_valid && st_reg.ff_n;
    assign do_write   = stage_pop;                               // [RULE9] [RULE17]
    assign do_read    = offset_load_n && !read_enable_n && st_reg.ef_n; // [RULE10] [RULE18]

    // Each side judges the fill level against the synchronised far pointer.
    assign wcount = st_reg.wptr - gray2bin(st_reg.rgray_s2);    // [RULE26]
    assign rcount = gray2bin(st_reg.wgray_s2) - st_reg.rptr;    // [RULE26]
    assign ucount = st_reg.wptr - st_reg.rptr;
    assign wptr_nx   = do_write ? ptr_inc(st_reg.wptr) : st_reg.wptr;
    assign rptr_nx   = retransmit_pulse ? '0 : (do_read ? ptr_inc(st_reg.rptr) : st_reg.rptr);
    assign wcount_nx = wptr_nx - gray2bin(st_reg.rgray_s2);
    assign rcount_nx = gray2bin(st_reg.wgray_s2) - rptr_nx;

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        st_next = st_reg;
        st_next.wptr  = wptr_nx;                                 // [RULE1]
        st_next.rptr  = rptr_nx;                                 // [RULE25]
        st_next.wgray = bin2gray(wptr_nx);
        st_next.rgray = bin2gray(rptr_nx);
        st_next.rgray_s1 = st_reg.rgray;                         // [RULE26]
        st_next.rgray_s2 = st_reg.rgray_s1;
        st_next.wgray_s1 = st_reg.wgray;
        st_next.wgray_s2 = st_reg.wgray_s1;
        st_next.ready = stage_ready;

        if (prog_write) begin
            if (st_reg.wsel == DCF_SEL_EMPTY_OFS) begin           // [RULE11] [RULE14]
                st_next.empty_threshold_offset = write_data_in[OW-1:0];
                st_next.wsel = DCF_SEL_FULL_OFS;
            end else begin
                st_next.full_threshold_offset = write_data_in[OW-1:0];
                st_next.wsel = DCF_SEL_EMPTY_OFS;                // [RULE15]
            end
        end

        if (prog_read) begin
            if (st_reg.rsel == DCF_SEL_EMPTY_OFS) begin           // [RULE16]
                st_next.qdata = DW'(st_reg.empty_threshold_offset);
                st_next.rsel  = DCF_SEL_FULL_OFS;
            end else begin
                st_next.qdata = DW'(st_reg.full_threshold_offset);
                st_next.rsel  = DCF_SEL_EMPTY_OFS;
            end
        end else if (do_read) begin
            st_next.qdata  = mem_reg[st_reg.rptr[AW-1:0]];        // [RULE6]
            st_next.primed = 1'b1;
        end

        // Outputs are driven whenever output_enable_n is low outside a clear, not only when read-enabled as cascades need.
        st_next.qoe = (!output_enable_n) ? '1 : '0;              // [RULE7] [RULE8]

        st_next.ff_n = (wcount_nx != DEPTH_W);                   // [RULE17] [RULE22]
        st_next.hf_n = !(ucount > HALF_W);                       // [RULE22]
        st_next.ef_n = (rcount_nx != '0);                        // [RULE18] [RULE21]

        if (flag_sync_select) begin
            // Asynchronous mode uses the undelayed count for quicker flags.
            st_next.pae_n = !near_empty(ucount, st_reg.empty_threshold_offset); // [RULE19] [RULE20]
            st_next.paf_n = !near_full(ucount, st_reg.full_threshold_offset);
        end else begin
            st_next.pae_n = !near_empty(rcount_nx, st_reg.empty_threshold_offset); // [RULE20] [RULE21]
            st_next.paf_n = !near_full(wcount_nx, st_reg.full_threshold_offset);   // [RULE22]
        end

        st_next.wxo_n = !(do_write && st_reg.wptr[AW-1:0] == AW'(DEPTH-1)); // [RULE27]
        st_next.rxo_n = !(do_read && st_reg.rptr[AW-1:0] == AW'(DEPTH-1));  // [RULE27]
    end

    ////////////////////////////////////////////////////////////////////////////////

    // The array has no reset; a clear only moves the pointers, and the empty
    // flag then keeps stale words from being read, even after a retransmit.
    always_ff @(posedge clk) begin
        if (do_write) begin
            mem_reg[st_reg.wptr[AW-1:0]] <= stage_data;          // [RULE1] [RULE5]
        end
    end

    always_ff @(posedge clk) begin
        if (clr) begin
            st_reg <= '0;                                        // [RULE2] [RULE3]
            st_reg.qoe   <= '0;
            st_reg.ready <= 1'b0;
            st_reg.ef_n  <= 1'b0;                                // [RULE2]
            st_reg.ff_n  <= 1'b1;
            st_reg.hf_n  <= 1'b1;
            st_reg.pae_n <= 1'b0;
            st_reg.paf_n <= 1'b1;
            st_reg.wxo_n <= 1'b1;
            st_reg.rxo_n <= 1'b1;
            st_reg.empty_threshold_offset <= DCF_OFFSET_RESET;   // [RULE12] [RULE13]
            st_reg.full_threshold_offset  <= DCF_OFFSET_RESET;   // [RULE13]
            st_reg.wsel <= DCF_SEL_EMPTY_OFS;
            st_reg.rsel <= DCF_SEL_EMPTY_OFS;
        end else begin
            st_reg <= st_next;                                   // [RULE23]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    assign read_data_out            = st_reg.qdata;              // [RULE3] [RULE10]
    assign read_data_oe             = st_reg.qoe;                // [RULE7]
    assign write_ready              = st_reg.ready;
    assign empty_indicator_n        = st_reg.ef_n;
    assign full_indicator_n         = st_reg.ff_n;
    assign half_level_indicator_n   = st_reg.hf_n;
    assign almost_empty_indicator_n = st_reg.pae_n;
    assign almost_full_indicator_n  = st_reg.paf_n;
    assign write_cascade_out_n      = st_reg.wxo_n;
    assign read_cascade_out_n       = st_reg.rxo_n;

endmodule

`default_nettype wire

// *** testbench/dcf_reader_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module dcf_reader_model (
    input  wire logic clk,
    input  wire logic run,
    output logic      read_enable_n
);
    // Random stalls exercise the output hold while no read is taken.
    always @(negedge clk) begin
        read_enable_n <= !(run && ($urandom_range(0, 2) != 0));
    end
endmodule

`default_nettype wire

// *** testbench/dcf_fifo_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none

module dcf_fifo_monitor
    import dcf_pkg::*;
(
    input wire logic                           clk,
    input wire logic                           rst,
    input wire logic                           buffer_clear_n,
    input wire logic                           read_enable_n,
    input wire logic                           output_enable_n,
    input wire logic                           offset_load_n,
    input wire logic [dcf_pkg::DCF_DATA_W-1:0] read_data_out,
    input wire logic [dcf_pkg::DCF_DATA_W-1:0] read_data_oe,
    input wire logic                           empty_indicator_n,
    input wire logic                           full_indicator_n,
    input wire logic                           half_level_indicator_n,
    input wire logic                           almost_empty_indicator_n,
    input wire logic                           write_cascade_out_n,
    input wire logic                           read_cascade_out_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence clr_s; !buffer_clear_n; endsequence
    sequence clr_state_s;
        read_data_out == '0 && !empty_indicator_n && !almost_empty_indicator_n
            && full_indicator_n && half_level_indicator_n;
    endsequence
    // Pointer sync lag means a read shortly before may still release full.
    sequence full_idle_s;
        (!full_indicator_n && read_enable_n && buffer_clear_n) [*6];
    endsequence

    AST_CLEAR: assert property (clr_s |=> clr_state_s)
        else $error("clear state wrong");
    AST_OE_OFF: assert property (output_enable_n |=> read_data_oe == '0)
        else $error("outputs driven while disabled");
    AST_OE_ON: assert property (!output_enable_n && buffer_clear_n |=> &read_data_oe)
        else $error("outputs not driven while enabled");
    AST_EMPTY_HOLD: assert property (!empty_indicator_n && !read_enable_n && offset_load_n
        && buffer_clear_n |=> $stable(read_data_out)) else $error("read taken while empty");
    AST_STANDS: assert property (read_enable_n && buffer_clear_n |=> $stable(read_data_out))
        else $error("output changed without read");
    AST_FULL_HOLD: assert property (full_idle_s |=> !full_indicator_n)
        else $error("full released without read");
    AST_HALF: assert property ($fell(full_indicator_n) |-> !half_level_indicator_n)
        else $error("full without half level");
    AST_CASC_W: assert property ($fell(write_cascade_out_n) |=> write_cascade_out_n)
        else $error("write cascade pulse too long");
    AST_CASC_R: assert property ($fell(read_cascade_out_n) |=> read_cascade_out_n)
        else $error("read cascade pulse too long");
endmodule

bind dcf_fifo dcf_fifo_monitor u_dcf_fifo_monitor (.clk, .rst, .buffer_clear_n, .read_enable_n,
    .output_enable_n, .offset_load_n, .read_data_out, .read_data_oe, .empty_indicator_n,
    .full_indicator_n, .half_level_indicator_n, .almost_empty_indicator_n,
    .write_cascade_out_n, .read_cascade_out_n);

`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module tb;
    import dcf_pkg::*;
    localparam int unsigned DEPTH = 16;
    logic                  clk = 1'b0, rst = 1'b1, clr_n = 1'b0, wen_n = 1'b1, ld_n = 1'b1;
    logic                  tb_ren_n = 1'b1, oe_n = 1'b1, run = 1'b0, take = 1'b0;
    logic [DCF_DATA_W-1:0] wdata = '0, dout, doe, exp_q[$];
    logic                  m_ren_n, wrdy, ef_n, ff_n, hf_n, ae_n, af_n, wxo_n, rxo_n;
    wire                   ren_n = m_ren_n & tb_ren_n;
    wire  [4:0]            flg = {ff_n, af_n, hf_n, ae_n, ef_n};
    int                    err_count = 0, total_checks = 0, cyc = 0;

    always #12.5 clk = ~clk;
    always @(negedge clk) oe_n <= 1'($urandom);

    dcf_fifo #(.DEPTH(DEPTH)) u_dcf_fifo (.clk(clk), .rst(rst), .buffer_clear_n(clr_n),
        .write_enable_n(wen_n), .read_enable_n(ren_n), .output_enable_n(oe_n),
        .offset_load_n(ld_n), .flag_sync_select(1'b0), .retransmit_pulse(1'b0),
        .write_cascade_in_n(1'b1), .read_cascade_in_n(1'b1), .write_data_in(wdata),
        .read_data_out(dout), .read_data_oe(doe), .write_ready(wrdy),
        .empty_indicator_n(ef_n), .full_indicator_n(ff_n), .half_level_indicator_n(hf_n),
        .almost_empty_indicator_n(ae_n), .almost_full_indicator_n(af_n),
        .write_cascade_out_n(wxo_n), .read_cascade_out_n(rxo_n));
    dcf_reader_model u_dcf_reader_model (.clk(clk), .run(run), .read_enable_n(m_ren_n));

    ////////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [17:0] s, input logic [17:0] e);
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Called at a falling edge; returns two cycles later so the strobe is never doubled.
    task automatic wr(input logic [17:0] d, input logic ofs);
        ld_n = !ofs;
        wen_n = 1'b0;
        wdata = d;
        if (!ofs) exp_q.push_back(d);
        @(negedge clk);
        wen_n = 1'b1;
        ld_n = 1'b1;
        @(negedge clk);
    endtask

    task automatic rb(input logic [17:0] e);
        ld_n = 1'b0;
        tb_ren_n = 1'b0;
        exp_q.push_back(e);
        @(negedge clk);
        ld_n = 1'b1;
        tb_ren_n = 1'b1;
        @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) take <= !rst && clr_n && !ren_n && (!ld_n || ef_n === 1'b1);
    always @(negedge clk) begin
        if (take) chk("rdata", dout, exp_q.size() ? exp_q.pop_front() : 'x);
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            finish_test();
        end
    end

    initial begin
        void'($urandom(27));
        repeat (6) @(negedge clk);
        rst = 1'b0;
        clr_n = 1'b1;
        rb(18'h0_007F);
        rb(18'h0_007F);
        wr(18'h0_0005, 1'b1);
        wr(18'h0_0004, 1'b1);
        wr(18'h3_0003, 1'b1);
        repeat (4) @(negedge clk);
        rb(18'h0_0003);
        rb(18'h0_0004);
        for (int i = 0; i < 3; i++) wr(18'($urandom), 1'b0);
        repeat (10) @(negedge clk);
        chk("flags", 18'(flg), 18'h0_001D);
        wr(18'($urandom), 1'b0);
        repeat (10) @(negedge clk);
        chk("flags", 18'(flg), 18'h0_001F);
        for (int i = 0; i < 40; i++) begin
            repeat (2) @(negedge clk);
            if (wrdy === 1'b1) wr(18'($urandom), 1'b0);
        end
        repeat (10) @(negedge clk);
        chk("flags", 18'(flg), 18'h0_0003);
        chk("ready", 18'(wrdy), 18'h0_0000);
        run = 1'b1;
        for (int i = 0; i < 600 && exp_q.size() != 0; i++) @(negedge clk);
        repeat (10) @(negedge clk);
        chk("flags", 18'(flg), 18'h0_001C);
        run = 1'b0;
        wr(18'($urandom), 1'b0);
        wr(18'($urandom), 1'b0);
        repeat (6) @(negedge clk);
        clr_n = 1'b0;
        exp_q.delete();
        repeat (2) @(negedge clk);
        chk("dout", dout, 18'h0_0000);
        chk("flags", 18'(flg & 5'h03), 18'h0_0000);
        clr_n = 1'b1;
        @(negedge clk);
        wr(18'($urandom), 1'b0);
        run = 1'b1;
        repeat (20) @(negedge clk);
        chk("left", 18'(exp_q.size()), 18'h0_0000);
        finish_test();
    end
endmodule

`default_nettype wire
